// ===== verilog/ssb_port_regs.sv
//
// Contract
// - I2C master clock is oscillator over four times reload plus one.
// - Reload SPI master clock likewise; software avoids reload zero.
// - One serial clock period spans two counter rollovers.
// - SPI master samples at bit end if phase bit set, else mid-bit.
// - In I2C the phase bit set disables slew limiting.
// - SPI edge bit picks active-to-idle or idle-to-active output change.
// - In I2C the edge bit selects SMBus input thresholds.
// - I2C data flag shows whether the last byte was data.
// - Stop and start flags mark the latest condition; cleared when off.
// - I2C slave direction flag holds last match read/write bit.
// - I2C master direction flag shows transmit; OR with requests is busy.
// - Update-address flag set in 10-bit slave mode when needed.
// - Full flag marks unread byte, or I2C transmit data shifting.
// - Master buffer write when start not allowed sets collision.
// - Slave buffer write while transmitting sets collision; software clears.
// - SPI slave overflow on unread buffer discards byte; never in master.
// - I2C overflow set when byte arrives with buffer still full.
// - Enable bit hands the serial pins to the port, except in reserved modes.
// - SPI polarity sets idle level; I2C slave clear bit stretches.
// - Mode field selects SPI, I2C, firmware master or reserved modes.
// - Master buffer write starts the reload counter.
// - Counter stops at completion; clock pin holds its level.
// - Reload copied into the counter twice per clock period.
`include "ssb_defs.svh"

module ssb_port_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire ssb_pkg::ssb_bus_t bus,
  input wire ssb_pkg::ssb_evt_t evt,
  input wire logic timer_two_output,
  output logic [7:0] rdata_reg,
  output ssb_pkg::ssb_pins_t pins_reg,
  output logic [7:0] tx_byte_reg,
  output logic tx_load_reg,
  output logic port_idle_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic sample_phase_reg;
  logic clock_edge_reg;
  logic data_flag_reg;
  logic stop_seen_reg;
  logic start_seen_reg;
  logic dir_reg;
  logic update_address_reg;
  logic buffer_full_reg;
  logic write_collision_reg;
  logic receive_overflow_reg;
  logic port_enable_reg;
  logic clock_polarity_reg;
  logic [3:0] port_mode_reg;
  logic [7:0] baud_reload_value_reg;
  logic [7:0] serial_buffer_reg;
  ssb_pkg::ssb_state_t state_reg;
  logic [4:0] roll_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_status, wr_ctrl, wr_reload, wr_buf, rd_buf;
  logic mode_res, spi_master, spi_slave, i2c_slave, i2c_master;
  logic i2c_any, ten_bit, is_master, active, run;
  logic start_ok, collide, rx_take, rx_over, last_roll, data_done;
  logic dir_eff, level, roll, ext_sel;
  logic [7:0] reload_sel;
  logic [4:0] roll_limit;

  // Register port strobes
  assign wr_status = bus.wr & (bus.addr == `SSB_OFS_STATUS);
  assign wr_ctrl = bus.wr & (bus.addr == `SSB_OFS_CTRL1);
  assign wr_reload = bus.wr & (bus.addr == `SSB_OFS_RELOAD);
  assign wr_buf = bus.wr & (bus.addr == `SSB_OFS_BUFFER);
  assign rd_buf = bus.rd & (bus.addr == `SSB_OFS_BUFFER);

  // Mode classes
  // mode field decode
  assign mode_res = (port_mode_reg == `SSB_M_RSV9) |
                    (port_mode_reg == `SSB_M_RSVC) |
                    (port_mode_reg == `SSB_M_RSVD);
  assign spi_master = (port_mode_reg <= `SSB_M_SPI_TMR) |
                      (port_mode_reg == `SSB_M_SPI_RELOAD);
  assign spi_slave = (port_mode_reg == `SSB_M_SPI_SLV_SEL) |
                     (port_mode_reg == `SSB_M_SPI_SLV);
  assign ten_bit = (port_mode_reg == `SSB_M_I2C_S10) |
                   (port_mode_reg == `SSB_M_I2C_S10_SP);
  assign i2c_slave = ten_bit |
                     (port_mode_reg == `SSB_M_I2C_S7) |
                     (port_mode_reg == `SSB_M_I2C_S7_SP);
  assign i2c_master = (port_mode_reg == `SSB_M_I2C_MST);
  assign i2c_any = i2c_slave | i2c_master |
                   (port_mode_reg == `SSB_M_I2C_FW);
  assign is_master = spi_master | i2c_master;
  // reserved codes leave the port inert
  assign active = port_enable_reg & ~mode_res;
  assign run = (state_reg == ssb_pkg::SSB_RUN);

  // Buffer write outcome: start, store, or collision
  // master start permission
  assign start_ok = active & is_master &
                    (state_reg == ssb_pkg::SSB_IDLE) &
                    ~(i2c_master & (|evt.seq_req));
  assign collide = active & wr_buf &
                   ((is_master & ~start_ok) |
                    (~is_master & evt.slv_tx_busy));

  // Receive outcome
  assign rx_take = active & evt.rx_valid & ~buffer_full_reg;
  assign rx_over = active & evt.rx_valid & buffer_full_reg &
                   (spi_slave | i2c_any);

  ////////////////////////////////////////////////////////////////////////////
  // Reload counter

  // Fixed reloads for the plain dividers and timer mode, else software value
  // I2C master uses software reload
  always_comb begin
    case (port_mode_reg)
      `SSB_M_SPI_D4: reload_sel = `SSB_RL_D4;
      `SSB_M_SPI_D16: reload_sel = `SSB_RL_D16;
      `SSB_M_SPI_D64: reload_sel = `SSB_RL_D64;
      `SSB_M_SPI_TMR: reload_sel = `SSB_RL_D4;
      default: reload_sel = baud_reload_value_reg;
    endcase
  end
  assign ext_sel = (port_mode_reg == `SSB_M_SPI_TMR);

  ssb_reload_counter #(
    .W(8)
  ) u_counter (
    .clock(clock),
    .rst_n(rst_n),
    .run(run),
    .ext_sel(ext_sel),
    .ext_tick(timer_two_output),
    .reload(reload_sel),
    .level_reg(level),
    .roll_reg(roll)
  );

  // two rollovers per bit; I2C adds the ack bit
  assign roll_limit = i2c_master ? `SSB_ROLLS_I2C : `SSB_ROLLS_SPI;
  assign last_roll = roll & (roll_cnt_reg == roll_limit - 5'h01);
  assign data_done = roll &
                     (roll_cnt_reg == `SSB_ROLLS_DATA - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  // Holding a one-hot state lets a stray code fall back to idle
  // write starts the counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ssb_pkg::SSB_IDLE;
      roll_cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        ssb_pkg::SSB_IDLE: begin
          roll_cnt_reg <= 5'h00;
          if (wr_buf & start_ok) begin
            state_reg <= ssb_pkg::SSB_RUN;
          end
        end
        ssb_pkg::SSB_RUN: begin
          if (!active | last_roll) begin
            state_reg <= ssb_pkg::SSB_IDLE;
          end
          if (roll) begin
            roll_cnt_reg <= roll_cnt_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= ssb_pkg::SSB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register one and reload value

  // Collision and overflow: set wins over a software clear
  // software clears by writing zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_collision_reg <= 1'b0;
      receive_overflow_reg <= 1'b0;
    end else begin
      if (collide) begin
        write_collision_reg <= 1'b1;
      end else if (wr_ctrl & ~bus.wdata[`SSB_C1_COLL]) begin
        write_collision_reg <= 1'b0;
      end
      if (rx_over) begin
        receive_overflow_reg <= 1'b1;
      end else if (wr_ctrl & ~bus.wdata[`SSB_C1_OVER]) begin
        receive_overflow_reg <= 1'b0;
      end
    end
  end

  // Plain writable control fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_enable_reg <= 1'(`SSB_RST_CTRL1 >> `SSB_C1_ENABLE);
      clock_polarity_reg <= 1'b0;
      port_mode_reg <= 4'h0;
      baud_reload_value_reg <= `SSB_RST_RELOAD;
    end else begin
      if (wr_ctrl) begin
        port_enable_reg <= bus.wdata[`SSB_C1_ENABLE];
        clock_polarity_reg <= bus.wdata[`SSB_C1_POL];
        port_mode_reg <= bus.wdata[`SSB_C1_MODE_HI:0];
      end
      if (wr_reload) begin
        baud_reload_value_reg <= bus.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  // Software-writable configuration bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_phase_reg <= 1'b0;
      clock_edge_reg <= 1'b0;
    end else if (wr_status) begin
      sample_phase_reg <= bus.wdata[`SSB_ST_SAMPLE];
      clock_edge_reg <= bus.wdata[`SSB_ST_EDGE];
    end
  end

  // Bus conditions; the newer one wins, disable clears both
  // latest condition, cleared when off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (!port_enable_reg) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (active & i2c_any & evt.start_seen) begin
      start_seen_reg <= 1'b1;
      stop_seen_reg <= 1'b0;
    end else if (active & i2c_any & evt.stop_seen) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b1;
    end
  end

  // Byte kind and slave direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_flag_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else if (active & i2c_any) begin
      if (evt.rx_valid) begin
        data_flag_reg <= evt.rx_is_data;
      end
      // valid until start, stop or nack
      if (evt.addr_match & i2c_slave) begin
        dir_reg <= evt.addr_rw;
      end else if (evt.start_seen | evt.stop_seen | evt.nack_seen) begin
        dir_reg <= 1'b0;
      end
    end
  end

  // address update request, cleared by rewrite
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      update_address_reg <= 1'b0;
    end else if (active & ten_bit & evt.update_req) begin
      update_address_reg <= 1'b1;
    end else if (wr_reload | ~ten_bit) begin
      update_address_reg <= 1'b0;
    end
  end

  // full on receive or I2C data shift
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buffer_full_reg <= 1'b0;
    end else if (rx_take | (wr_buf & start_ok & i2c_master)) begin
      buffer_full_reg <= 1'b1;
    end else if (rd_buf | (run & i2c_master & data_done)) begin
      buffer_full_reg <= 1'b0;
    end
  end

  // Buffer keeps an unread byte; collided writes are dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_buffer_reg <= `SSB_RST_BUFFER;
    end else if (rx_take) begin
      serial_buffer_reg <= evt.rx_byte;
    end else if (wr_buf & ~collide) begin
      serial_buffer_reg <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and engine handoff

  // master direction reads transmit in progress
  assign dir_eff = i2c_master ? run : dir_reg;

  // Read data stand for one cycle only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (!bus.rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (bus.addr)
        `SSB_OFS_STATUS: rdata_reg <= {sample_phase_reg, clock_edge_reg,
            data_flag_reg, stop_seen_reg, start_seen_reg, dir_eff,
            update_address_reg & ten_bit, buffer_full_reg};
        `SSB_OFS_CTRL1: rdata_reg <= {write_collision_reg,
            receive_overflow_reg, port_enable_reg, clock_polarity_reg,
            port_mode_reg};
        `SSB_OFS_RELOAD: rdata_reg <= baud_reload_value_reg;
        default: rdata_reg <= serial_buffer_reg;
      endcase
    end
  end

  // idle is neither transmitting nor any request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_idle_reg <= 1'b1;
      tx_load_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else begin
      port_idle_reg <= ~(dir_eff | (|evt.seq_req));
      tx_load_reg <= wr_buf & ~collide & active;
      if (wr_buf & ~collide) begin
        tx_byte_reg <= bus.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin controls

  // All pin controls registered so the pads see no decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_reg <= '0;
    end else begin
      // pins to the port while enabled, except in reserved modes
      pins_reg.pins_en <= active;
      pins_reg.spi_clock_o <= clock_polarity_reg ^ level;
      pins_reg.spi_clock_oe <= active & spi_master;
      pins_reg.scl_low_oe <= active &
          ((i2c_master & run & ~level) |
           (i2c_slave & ~clock_polarity_reg));
      // slew limit when phase bit clear
      pins_reg.slew_limit <= active & i2c_any & ~sample_phase_reg;
      pins_reg.smbus_levels <= active & i2c_any & clock_edge_reg;
      // even rollover is mid-bit, odd is bit end
      pins_reg.sample_strobe <= active & spi_master & run & roll &
          (roll_cnt_reg[0] == sample_phase_reg);
      // output change edge by edge bit
      pins_reg.shift_strobe <= active & spi_master & run & roll &
          (roll_cnt_reg[0] == clock_edge_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence tx_go_s;
    wr_buf & start_ok & i2c_master;
  endsequence

  i2c_full_tx_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    tx_go_s |=> buffer_full_reg & run)
    else $error("full flag not set on transmit");

  start_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_buf & start_ok |=> run ##1 roll_cnt_reg == 5'h00)
    else $error("buffer write did not start");

  master_coll_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_buf & active & is_master & run |=> write_collision_reg)
    else $error("busy master write not flagged");

  slave_coll_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_buf & active & spi_slave & evt.slv_tx_busy
      |=> write_collision_reg & $stable(serial_buffer_reg))
    else $error("slave collision missed");

  overflow_drop_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    active & spi_slave & evt.rx_valid & buffer_full_reg
      |=> receive_overflow_reg & $stable(serial_buffer_reg))
    else $error("overflow not flagged or byte kept");

  no_master_ov_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(receive_overflow_reg) |-> !$past(spi_master))
    else $error("overflow set in master");

  cond_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !port_enable_reg |=> !start_seen_reg & !stop_seen_reg)
    else $error("conditions kept while disabled");

  reserved_inert_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    mode_res ##1 mode_res |-> !pins_reg.pins_en & !pins_reg.scl_low_oe)
    else $error("reserved mode drives pins");

  stretch_low_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    active & i2c_slave & !clock_polarity_reg |=> pins_reg.scl_low_oe)
    else $error("slave clock not stretched");

  master_dir_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd & bus.addr == `SSB_OFS_STATUS & i2c_master & run
      |=> rdata_reg[`SSB_ST_DIR])
    else $error("master direction not shown");

endmodule // ssb_port_regs

// ===== inc/ssb_defs.svh
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

// Register offsets on the plain register port
`define SSB_OFS_STATUS 2'h0
`define SSB_OFS_CTRL1 2'h1
`define SSB_OFS_RELOAD 2'h2
`define SSB_OFS_BUFFER 2'h3

// Reset values
`define SSB_RST_STATUS 8'h00
`define SSB_RST_CTRL1 8'h00
`define SSB_RST_RELOAD 8'h00
`define SSB_RST_BUFFER 8'h00

// Status register bit positions
`define SSB_ST_SAMPLE 7
`define SSB_ST_EDGE 6
`define SSB_ST_DATA 5
`define SSB_ST_STOP 4
`define SSB_ST_START 3
`define SSB_ST_DIR 2
`define SSB_ST_UPDATE 1
`define SSB_ST_FULL 0

// Control register one bit positions
`define SSB_C1_COLL 7
`define SSB_C1_OVER 6
`define SSB_C1_ENABLE 5
`define SSB_C1_POL 4
`define SSB_C1_MODE_HI 3

// Mode field codes
`define SSB_M_SPI_D4 4'h0
`define SSB_M_SPI_D16 4'h1
`define SSB_M_SPI_D64 4'h2
`define SSB_M_SPI_TMR 4'h3
`define SSB_M_SPI_SLV_SEL 4'h4
`define SSB_M_SPI_SLV 4'h5
`define SSB_M_I2C_S7 4'h6
`define SSB_M_I2C_S10 4'h7
`define SSB_M_I2C_MST 4'h8
`define SSB_M_RSV9 4'h9
`define SSB_M_SPI_RELOAD 4'hA
`define SSB_M_I2C_FW 4'hB
`define SSB_M_RSVC 4'hC
`define SSB_M_RSVD 4'hD
`define SSB_M_I2C_S7_SP 4'hE
`define SSB_M_I2C_S10_SP 4'hF

// Fixed reloads giving clock/4, clock/16 and clock/64
`define SSB_RL_D4 8'h00
`define SSB_RL_D16 8'h03
`define SSB_RL_D64 8'h0F

// Counter rollovers per transfer: two per bit
`define SSB_ROLLS_SPI 5'h10
`define SSB_ROLLS_I2C 5'h12
`define SSB_ROLLS_DATA 5'h10

`endif

// ===== inc/ssb_pkg.sv
package ssb_pkg;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    SSB_IDLE = 2'h1,
    SSB_RUN = 2'h2
  } ssb_state_t;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssb_bus_t;

  // Events reported by the protocol engine
  typedef struct packed {
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_is_data;
    logic start_seen;
    logic stop_seen;
    logic addr_match;
    logic addr_rw;
    logic nack_seen;
    logic update_req;
    logic slv_tx_busy;
    logic [4:0] seq_req;
  } ssb_evt_t;

  // Pin and engine controls
  typedef struct packed {
    logic pins_en;
    logic spi_clock_o;
    logic spi_clock_oe;
    logic scl_low_oe;
    logic slew_limit;
    logic smbus_levels;
    logic sample_strobe;
    logic shift_strobe;
  } ssb_pins_t;

endpackage

// ===== verilog/ssb_reload_counter.sv
`include "ssb_defs.svh"

module ssb_reload_counter #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic ext_sel,
  input wire logic ext_tick,
  input wire logic [W-1:0] reload,
  output logic level_reg,
  output logic roll_reg
);

  logic half_reg;
  logic [W-1:0] count_reg;
  logic tick;
  logic zero;

  // Oscillator/2 step, or the timer pulse in timer mode
  assign tick = ext_sel ? ext_tick : half_reg;
  assign zero = (count_reg == '0);

  // Prescaler realigns on every start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= run & ~half_reg;
    end
  end

  // Countdown; reload twice per output period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!run) begin
      count_reg <= reload;
    end else if (tick) begin
      count_reg <= zero ? reload : count_reg - 1'b1;
    end
  end

  // Level toggles per rollover; held while stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
      roll_reg <= 1'b0;
    end else begin
      roll_reg <= run & tick & zero;
      if (run & tick & zero) begin
        level_reg <= ~level_reg;
      end
    end
  end

  // Gap checker helper
  logic [W+1:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= roll_reg ? (W+2)'(1) : gap_reg + 1'b1;
      seen_reg <= run & (seen_reg | roll_reg);
    end
  end

  roll_gap_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    roll_reg & seen_reg & run & !ext_sel & $stable(reload)
      |-> gap_reg == {1'b0, reload, 1'b0} + (W+2)'(2))
    else $error("rollover spacing wrong");

  level_roll_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(level_reg) == $past(run & tick & zero))
    else $error("level toggle without rollover");

  stop_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !run ##1 !run |-> $stable(level_reg))
    else $error("clock level moved while stopped");

endmodule // ssb_reload_counter

// ===== tb/ssb_far_end.sv
// Stand-in for the protocol engine facing remote bus devices
module ssb_far_end (
  input wire logic clock,
  output ssb_pkg::ssb_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial evt = '0;
  ////////////////////////////////////////////////////////////////////
  // One-cycle event pulse, then all quiet again
  task automatic send(input ssb_pkg::ssb_evt_t e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= '0;
  endtask
  task automatic byte_in(input logic [7:0] b, input logic d);
    send('{1'b1, b, d, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00});
  endtask
  task automatic cond(input logic s, input logic p, input logic m);
    send('{1'b0, 8'h00, 1'b0, s, p, m, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00});
  endtask
  // Ten-bit slave asks for an address rewrite
  task automatic addr_update;
    send('{1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
           1'b1, 1'b0, 5'h00});
  endtask
  // Slave transmit busy is a level, held until changed
  task automatic busy(input logic b);
    @(posedge clock);
    evt.slv_tx_busy <= b;
  endtask
endmodule // ssb_far_end

// ===== tb/sync_serial_status_ctrl_brg_test.sv
module sync_serial_status_ctrl_brg_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  ssb_pkg::ssb_bus_t bus = '0;
  ssb_pkg::ssb_evt_t evt;
  ssb_pkg::ssb_pins_t pins_reg;
  logic [7:0] rdata_reg;
  logic [7:0] tx_byte_reg;
  logic tx_load_reg;
  logic port_idle_reg;
  int n_fail = 0;
  int compares = 0;
  int c;
  logic tick = 1'b0;
  always #50 clock = ~clock;
  // Timer tick driven by the bench for the timer clock mode
  ssb_port_regs DUT (.clock(clock), .rst_n(rst_n), .bus(bus), .evt(evt),
    .timer_two_output(tick), .rdata_reg(rdata_reg), .pins_reg(pins_reg),
    .tx_byte_reg(tx_byte_reg), .tx_load_reg(tx_load_reg),
    .port_idle_reg(port_idle_reg));
  ssb_far_end far (.clock(clock), .evt(evt));
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  // Register port: strobe for one cycle, read data only the cycle after
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk("rdata", e, rdata_reg);
  endtask
  // Cycles until the serial clock level changes, bounded
  task automatic gap(output int n);
    logic v;
    #1 v = pins_reg.spi_clock_o;
    n = 0;
    while (pins_reg.spi_clock_o === v && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 300) begin
      n_fail++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(0, 8'h00);
    rd(1, 8'h00);
    // Only the two top status bits are writable; I2C pad controls
    wr(1, 8'h26);
    wr(0, 8'hFF);
    rd(0, 8'hC0);
    chk("slew", 8'h00, {7'h00, pins_reg.slew_limit});
    chk("smbus", 8'h01, {7'h00, pins_reg.smbus_levels});
    wr(0, 8'h00);
    @(posedge clock);
    #1 chk("slew", 8'h01, {7'h00, pins_reg.slew_limit});
    // Conditions, matched direction, then disable clears both flags
    far.cond(1'b1, 1'b0, 1'b0);
    rd(0, 8'h08);
    far.cond(1'b0, 1'b0, 1'b1);
    rd(0, 8'h0C);
    far.cond(1'b0, 1'b1, 1'b0);
    rd(0, 8'h10);
    wr(1, 8'h06);
    rd(0, 8'h00);
    // I2C receive: second byte with buffer full overflows
    wr(1, 8'h26);
    far.byte_in(8'h5A, 1'b1);
    rd(0, 8'h21);
    far.byte_in(8'hA5, 1'b0);
    rd(1, 8'h66);
    rd(3, 8'h5A);
    // Ten-bit slave: update request, cleared by a reload write
    wr(1, 8'h27);
    far.addr_update();
    rd(0, 8'h02);
    wr(2, 8'h10);
    rd(0, 8'h00);
    // SPI slave, phase bit kept at zero
    wr(1, 8'h25);
    far.byte_in(8'h3C, 1'b1);
    far.byte_in(8'hC3, 1'b1);
    rd(1, 8'h65);
    rd(3, 8'h3C);
    // Buffer write while the slave still transmits collides
    far.busy(1'b1);
    wr(3, 8'h77);
    far.busy(1'b0);
    rd(1, 8'hE5);
    rd(3, 8'h3C);
    // SPI master mode never flags overflow
    wr(1, 8'h20);
    far.byte_in(8'h11, 1'b1);
    far.byte_in(8'h22, 1'b1);
    rd(1, 8'h20);
    rd(3, 8'h11);
    wr(1, 8'h29);
    @(posedge clock);
    #1 chk("pins_en", 8'h00, {7'h00, pins_reg.pins_en});
    // Reload master: nonzero reload, half period of 2*(2+1) cycles
    wr(2, 8'h02);
    wr(1, 8'h2A);
    @(posedge clock);
    #1 chk("pins_en", 8'h01, {7'h00, pins_reg.pins_en});
    wr(3, 8'h96);
    gap(c);
    gap(c);
    chk("half_period", 8'h06, c[7:0]);
    gap(c);
    chk("half_period", 8'h06, c[7:0]);
    wr(3, 8'h11);
    rd(1, 8'hAA);
    // Sixteen rollovers of six cycles end well inside this wait
    repeat (120) @(posedge clock);
    #1 chk("idle", 8'h01, {7'h00, port_idle_reg});
    chk("sck", 8'h00, {7'h00, pins_reg.spi_clock_o});
    chk("tx", 8'h96, tx_byte_reg);
    // Software clears collision; polarity sets idle level
    wr(1, 8'h3A);
    rd(1, 8'h3A);
    @(posedge clock);
    #1 chk("sck", 8'h01, {7'h00, pins_reg.spi_clock_o});
    // I2C master: direction shows transmit, full while data shifts
    wr(2, 8'h03);
    wr(1, 8'h28);
    wr(3, 8'h5A);
    rd(0, 8'h05);
    chk("idle", 8'h00, {7'h00, port_idle_reg});
    repeat (130) @(posedge clock);
    rd(0, 8'h04);
    repeat (20) @(posedge clock);
    #1 chk("idle", 8'h01, {7'h00, port_idle_reg});
    rd(0, 8'h00);
    // Timer clock mode: every timer pulse is one rollover
    wr(1, 8'h23);
    wr(3, 8'h3C);
    repeat (3) begin
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
    end
    @(posedge clock);
    #1 chk("sck", 8'h01, {7'h00, pins_reg.spi_clock_o});
    finish_test();
  end
endmodule // sync_serial_status_ctrl_brg_test
